// file: rtl/occ_regs.svh
// register offsets, field positions, reset values and widths of the console control block
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

// register byte offsets on the avalon slave
`define OCC_STATUS_OFS   6'h00
`define OCC_MASK_OFS     6'h04
`define OCC_CONTROL_OFS  6'h08
`define OCC_PC_OFS       6'h0c
`define OCC_READOUT_OFS  6'h10
`define OCC_ERRLOC_OFS   6'h14
`define OCC_STATE_OFS    6'h18

// status and mask bit positions
`define OCC_EV_DEPOSIT   0
`define OCC_EV_EXAMINE   1
`define OCC_EV_MISMATCH  2
`define OCC_EV_HALT      3
`define OCC_EV_W         4

// control bit positions and reset values
`define OCC_CTL_COMPARE  0
`define OCC_CTL_RESET    1'h1
`define OCC_MASK_RESET   4'h0

// state register bit positions
`define OCC_ST_RUN       0
`define OCC_ST_HALT      1
`define OCC_ST_LAMP      2
`define OCC_ST_GO        3
`define OCC_ST_MODE      4

// mode select pin codes
`define OCC_CODE_SET_A   3'h0
`define OCC_CODE_SET_B   3'h1
`define OCC_CODE_SET_C   3'h2
`define OCC_CODE_SET_P   3'h3
`define OCC_CODE_EXEC    3'h4
`define OCC_CODE_DEPOSIT 3'h5
`define OCC_CODE_EXAMINE 3'h6

// function drive operands for the lamp
`define OCC_FD_LAMP_ON   4'h3
`define OCC_FD_LAMP_OFF  4'h2

`endif

// file: rtl/occ_pkg.sv
// types shared by the console control block
package occ_pkg;

    // selected console mode
    typedef enum logic [2:0] {
        MODE_SET_A,
        MODE_SET_B,
        MODE_SET_C,
        MODE_SET_P,
        MODE_EXEC,
        MODE_DEPOSIT,
        MODE_EXAMINE
    } occ_mode_e;

    // step sequencer for deposit and examine
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_DEP_WR,
        SEQ_DEP_RD,
        SEQ_DEP_CMP,
        SEQ_EX_RD,
        SEQ_EX_CMP
    } occ_seq_e;

endpackage

// file: rtl/operator_console_control.sv
// operator console control: panel loads, deposit, examine, run control, error lamp
//
// Function
// - load modes copy toggles into register at once
// - eighteen toggles supply all console data
// - deposit mode mirrors toggles into staging register
// - deposit step writes staging word, increments pc
// - deposit readback mismatch halts and sounds buzzer
// - examine step loads readout, increments pc
// - examine mismatch against toggles halts machine
// - lamp and buzzer only in memory modes
// - function drive 3 lamp on, 2 off
// - lamp on by instruction does not halt
// - stop switch, go, memory mode: lamp halts, logs
// - instructions run only in execute mode or under program lockout
// - go in execute mode starts at pc
// - program lockout forces run, disables all switches but the stop switch
// - manual lockout position enables every switch
// - toggle up or down reads one, center zero
`timescale 1ns/1ns
`include "occ_regs.svh"

module operator_console_control
    import occ_pkg::*;
#(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 13
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [5:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    output logic                   irq,
    input  wire logic [WORD_W-1:0] toggleUp,
    input  wire logic [WORD_W-1:0] toggleDown,
    input  wire logic [2:0]        modeSel,
    input  wire logic              stepButton,
    input  wire logic              goButton,
    input  wire logic              lockoutProgram,
    input  wire logic              stopOnError,
    input  wire logic [5:0]        resetButtons,
    input  wire logic              funcDriveValid,
    input  wire logic [3:0]        funcDriveOperand,
    output logic      [ADDR_W-1:0] memAddr,
    output logic      [WORD_W-1:0] memWrData,
    output logic                   memWrite,
    output logic                   memRead,
    input  wire logic [WORD_W-1:0] memRdData,
    output logic                   runEnable,
    output logic      [ADDR_W-1:0] pcOut,
    output logic      [WORD_W-1:0] regAOut,
    output logic      [WORD_W-1:0] regBOut,
    output logic      [WORD_W-1:0] regCOut,
    output logic      [WORD_W-1:0] readoutOut,
    output logic      [WORD_W-1:0] stageOut,
    output logic      [ADDR_W-1:0] errLocOut,
    output logic                   errorLamp,
    output logic                   buzzer,
    output logic                   haltLamp
);

    localparam int PANEL_W = 13;

    // whole state of the block
    typedef struct packed {
        logic [2*WORD_W-1:0] tglSync1;
        logic [2*WORD_W-1:0] tglSync2;
        logic [PANEL_W-1:0]  panSync1;
        logic [PANEL_W-1:0]  panSync2;
        logic [1:0]          btnPrev;
        occ_mode_e           mode;
        occ_seq_e            seq;
        logic                run;
        logic                halt;
        logic                goSeen;
        logic                lamp;
        logic                lampOut;
        logic [WORD_W-1:0]   regA;
        logic [WORD_W-1:0]   regB;
        logic [WORD_W-1:0]   regC;
        logic [WORD_W-1:0]   readout;
        logic [WORD_W-1:0]   stage;
        logic [ADDR_W-1:0]   pc;
        logic [ADDR_W-1:0]   errLoc;
        logic [`OCC_EV_W-1:0] status;
        logic [`OCC_EV_W-1:0] mask;
        logic                ctrlCmp;
        logic                rdPend;
        logic [31:0]         rdData;
    } occ_state_s;

    occ_state_s s_q;
    occ_state_s s_d;

    // synchronised panel view; only the second stage is read
    logic [WORD_W-1:0] tglWord;
    logic              stepS;
    logic              goS;
    logic              lockS;
    logic              stopS;
    logic [5:0]        rstS;
    logic [2:0]        modeS;
    logic              stepPress;
    logic              goPress;
    logic              memMode;
    logic              manual;
    logic              mismatch;
    logic              readAccept;
    logic              writeAccept;
    logic [31:0]       rdMux;
    logic [`OCC_EV_W-1:0] events;

    assign tglWord   = s_q.tglSync2[WORD_W-1:0] | s_q.tglSync2[2*WORD_W-1:WORD_W];
    assign stepS     = s_q.panSync2[0];
    assign goS       = s_q.panSync2[1];
    assign lockS     = s_q.panSync2[2];
    assign stopS     = s_q.panSync2[3];
    assign rstS      = s_q.panSync2[9:4];
    assign modeS     = s_q.panSync2[12:10];
    assign manual    = !lockS;
    assign stepPress = stepS && !s_q.btnPrev[0] && manual;
    assign goPress   = goS && !s_q.btnPrev[1] && manual;
    assign memMode   = (s_q.mode == MODE_DEPOSIT) || (s_q.mode == MODE_EXAMINE);

    // readback compare against the toggles after a deposit or examine read
    assign mismatch = s_q.ctrlCmp && (memRdData != tglWord)
                    && ((s_q.seq == SEQ_DEP_CMP) || (s_q.seq == SEQ_EX_CMP));

    // avalon handshake: reads take one wait cycle, writes none
    assign readAccept  = read && s_q.rdPend;
    assign writeAccept = write && !read;
    assign waitrequest = read && !readAccept;

    // read data mux, unmapped addresses read zero
    always_comb begin
        rdMux = 32'h0;
        case (address)
            `OCC_STATUS_OFS:  rdMux[`OCC_EV_W-1:0] = s_q.status;
            `OCC_MASK_OFS:    rdMux[`OCC_EV_W-1:0] = s_q.mask;
            `OCC_CONTROL_OFS: rdMux[`OCC_CTL_COMPARE] = s_q.ctrlCmp;
            `OCC_PC_OFS:      rdMux[ADDR_W-1:0] = s_q.pc;
            `OCC_READOUT_OFS: rdMux[WORD_W-1:0] = s_q.readout;
            `OCC_ERRLOC_OFS:  rdMux[ADDR_W-1:0] = s_q.errLoc;
            `OCC_STATE_OFS: begin
                rdMux[`OCC_ST_RUN]  = runEnable;
                rdMux[`OCC_ST_HALT] = s_q.halt;
                rdMux[`OCC_ST_LAMP] = s_q.lamp;
                rdMux[`OCC_ST_GO]   = s_q.goSeen;
                rdMux[`OCC_ST_MODE+2:`OCC_ST_MODE] = s_q.mode;
            end
            default: rdMux = 32'h0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;
        events = '0;

        // two-flop synchronisers for every panel input
        s_d.tglSync1 = {toggleDown, toggleUp};
        s_d.tglSync2 = s_q.tglSync1;
        s_d.panSync1 = {modeSel, resetButtons, stopOnError, lockoutProgram, goButton, stepButton};
        s_d.panSync2 = s_q.panSync1;
        s_d.btnPrev  = {goS, stepS};

        // mode select, frozen while locked out
        if (manual) begin
            case (modeS)
                `OCC_CODE_SET_A:   s_d.mode = MODE_SET_A;
                `OCC_CODE_SET_B:   s_d.mode = MODE_SET_B;
                `OCC_CODE_SET_C:   s_d.mode = MODE_SET_C;
                `OCC_CODE_SET_P:   s_d.mode = MODE_SET_P;
                `OCC_CODE_EXEC:    s_d.mode = MODE_EXEC;
                `OCC_CODE_DEPOSIT: s_d.mode = MODE_DEPOSIT;
                `OCC_CODE_EXAMINE: s_d.mode = MODE_EXAMINE;
                default:           s_d.mode = s_q.mode;
            endcase
        end
        if (s_d.mode != s_q.mode) begin
            s_d.goSeen = 1'b0;
        end

        // immediate register loads from the toggles
        if (manual) begin
            case (s_q.mode)
                MODE_SET_A:   s_d.regA = tglWord;
                MODE_SET_B:   s_d.regB = tglWord;
                MODE_SET_C:   s_d.regC = tglWord;
                MODE_SET_P:   s_d.pc = tglWord[ADDR_W-1:0];
                MODE_DEPOSIT: s_d.stage = tglWord;
                default:      s_d.stage = s_q.stage;
            endcase
        end

        // go and step buttons steer the run flip-flop
        if (goPress) begin
            if (s_q.mode == MODE_EXEC) begin
                s_d.run  = 1'b1;
                s_d.halt = 1'b0;
            end else if (memMode) begin
                s_d.goSeen = 1'b1;
            end
        end
        if (stepPress) begin
            s_d.run = 1'b0;
            if (memMode && s_q.seq == SEQ_IDLE) begin
                s_d.halt = 1'b0;
                s_d.seq  = (s_q.mode == MODE_DEPOSIT) ? SEQ_DEP_WR : SEQ_EX_RD;
            end
        end

        // deposit and examine sequencer
        case (s_q.seq)
            SEQ_IDLE:    s_d.seq = s_d.seq;
            SEQ_DEP_WR:  s_d.seq = SEQ_DEP_RD;
            SEQ_DEP_RD:  s_d.seq = SEQ_DEP_CMP;
            SEQ_DEP_CMP: begin
                s_d.pc  = s_q.pc + 1'b1;
                s_d.seq = SEQ_IDLE;
                events[`OCC_EV_DEPOSIT] = 1'b1;
            end
            SEQ_EX_RD:   s_d.seq = SEQ_EX_CMP;
            SEQ_EX_CMP: begin
                s_d.readout = memRdData;
                s_d.pc      = s_q.pc + 1'b1;
                s_d.seq     = SEQ_IDLE;
                events[`OCC_EV_EXAMINE] = 1'b1;
            end
            default: s_d.seq = SEQ_IDLE;
        endcase

        // compare failure lights the lamp and halts
        if (mismatch) begin
            s_d.lamp = 1'b1;
            s_d.halt = 1'b1;
            events[`OCC_EV_MISMATCH] = 1'b1;
        end

        // function drive instruction switches the lamp without halting
        if (funcDriveValid && funcDriveOperand == `OCC_FD_LAMP_ON) begin
            s_d.lamp = 1'b1;
        end else if (funcDriveValid && funcDriveOperand == `OCC_FD_LAMP_OFF) begin
            s_d.lamp = 1'b0;
        end

        // stop-on-error: a lamp turn-on halts and logs the address
        if (s_d.lamp && !s_q.lamp && memMode && s_q.goSeen && stopS) begin
            s_d.halt   = 1'b1;
            s_d.errLoc = s_q.pc;
        end
        if (s_d.halt && !s_q.halt) begin
            events[`OCC_EV_HALT] = 1'b1;
        end
        s_d.lampOut = s_d.lamp && ((s_d.mode == MODE_DEPOSIT) || (s_d.mode == MODE_EXAMINE));

        // lockout forces the run flip-flop on
        if (lockS) begin
            s_d.run = 1'b1;
        end

        // reset pushbuttons, held clear while pressed
        if (manual) begin
            if (rstS[0]) s_d.pc = '0;
            if (rstS[1]) s_d.regA = '0;
            if (rstS[2]) s_d.regB = '0;
            if (rstS[3]) s_d.readout = '0;
            if (rstS[4]) s_d.regC = '0;
            if (rstS[5]) s_d.stage = '0;
        end

        // register bus writes; hardware set wins over write-one clear
        s_d.status = s_q.status;
        if (writeAccept && byteenable[0]) begin
            case (address)
                `OCC_STATUS_OFS:  s_d.status = s_q.status & ~writedata[`OCC_EV_W-1:0];
                `OCC_MASK_OFS:    s_d.mask = writedata[`OCC_EV_W-1:0];
                `OCC_CONTROL_OFS: s_d.ctrlCmp = writedata[`OCC_CTL_COMPARE];
                default:          s_d.mask = s_q.mask;
            endcase
        end
        s_d.status = s_d.status | events;

        // read wait cycle and captured read data
        s_d.rdPend = read && !s_q.rdPend;
        if (read && !s_q.rdPend) begin
            s_d.rdData = rdMux;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge clock) begin
        if (reset) begin
            s_q         <= '0;
            s_q.mode    <= MODE_SET_A;
            s_q.seq     <= SEQ_IDLE;
            s_q.mask    <= `OCC_MASK_RESET;
            s_q.ctrlCmp <= `OCC_CTL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    assign runEnable  = (s_q.run && !s_q.halt && s_q.mode == MODE_EXEC) || lockS;
    assign memAddr    = s_q.pc;
    assign memWrData  = s_q.stage;
    assign memWrite   = (s_q.seq == SEQ_DEP_WR);
    assign memRead    = (s_q.seq == SEQ_DEP_RD) || (s_q.seq == SEQ_EX_RD);
    assign pcOut      = s_q.pc;
    assign regAOut    = s_q.regA;
    assign regBOut    = s_q.regB;
    assign regCOut    = s_q.regC;
    assign readoutOut = s_q.readout;
    assign stageOut   = s_q.stage;
    assign errLocOut  = s_q.errLoc;
    assign errorLamp  = s_q.lampOut;
    assign buzzer     = s_q.lampOut;
    assign haltLamp   = s_q.halt;
    assign readdata   = s_q.rdData;
    assign irq        = |(s_q.status & s_q.mask);

    property p_load_a;
        @(posedge clock) disable iff (reset)
        (s_q.mode == MODE_SET_A && manual && !rstS[1]) |=> (s_q.regA == $past(tglWord));
    endproperty
    a_load_a: assert property (p_load_a) else $error("register A did not follow toggles");

    property p_stage_mirror;
        @(posedge clock) disable iff (reset)
        (s_q.mode == MODE_DEPOSIT && manual && !rstS[5]) |=> (s_q.stage == $past(tglWord));
    endproperty
    a_stage_mirror: assert property (p_stage_mirror) else $error("staging not mirrored");

    property p_deposit_seq;
        @(posedge clock) disable iff (reset)
        memWrite |-> (memWrData == s_q.stage) ##1 memRead ##1 (s_q.seq == SEQ_DEP_CMP)
        ##1 (s_q.seq == SEQ_IDLE);
    endproperty
    a_deposit_seq: assert property (p_deposit_seq) else $error("deposit sequence broken");

    property p_deposit_inc;
        @(posedge clock) disable iff (reset)
        (s_q.seq == SEQ_DEP_CMP && manual && !rstS[0]) |=> (s_q.pc == $past(s_q.pc) + 1'b1);
    endproperty
    a_deposit_inc: assert property (p_deposit_inc) else $error("pc not incremented");

    property p_mismatch_halt;
        @(posedge clock) disable iff (reset)
        mismatch |=> (s_q.halt && s_q.lamp);
    endproperty
    a_mismatch_halt: assert property (p_mismatch_halt) else $error("mismatch did not halt");

    property p_examine_load;
        @(posedge clock) disable iff (reset)
        (s_q.seq == SEQ_EX_CMP && !(manual && rstS[3])) |=> (s_q.readout == $past(memRdData));
    endproperty
    a_examine_load: assert property (p_examine_load) else $error("readout not loaded");

    property p_lamp_modes;
        @(posedge clock) disable iff (reset)
        errorLamp |-> memMode;
    endproperty
    a_lamp_modes: assert property (p_lamp_modes) else $error("lamp lit outside memory modes");

    property p_lamp_off;
        @(posedge clock) disable iff (reset)
        (funcDriveValid && funcDriveOperand == `OCC_FD_LAMP_OFF) |=> !s_q.lamp;
    endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("lamp not turned off");

    property p_run_mode;
        @(posedge clock) disable iff (reset)
        runEnable |-> (s_q.mode == MODE_EXEC || lockS);
    endproperty
    a_run_mode: assert property (p_run_mode) else $error("running outside execute mode");

    property p_lockout_run;
        @(posedge clock) disable iff (reset)
        lockS |-> runEnable ##1 s_q.run;
    endproperty
    a_lockout_run: assert property (p_lockout_run) else $error("lockout did not force run");

endmodule

// file: verification/occ_memory_model.sv
// memory model standing behind the console block's memory port
`timescale 1ns/1ns

module occ_memory_model #(
    parameter int AW = 13,
    parameter int WW = 18
) (
    input  wire logic          clock,
    input  wire logic [AW-1:0] memAddr,
    input  wire logic [WW-1:0] memWrData,
    input  wire logic          memWrite,
    input  wire logic          memRead,
    input  wire logic          corrupt,
    output logic      [WW-1:0] memRdData
);
    logic [WW-1:0] store [0:(1<<AW)-1];

    // write on request; read data only valid the cycle after, scrambled otherwise
    always_ff @(posedge clock) begin
        if (memWrite) begin
            store[memAddr] <= memWrData;
        end
        if (memRead) begin
            memRdData <= store[memAddr] ^ {{(WW-1){1'b0}}, corrupt};
        end else begin
            memRdData <= ~memRdData;
        end
    end
endmodule

// file: verification/testbench.sv
// self-checking bench for the console control block
`timescale 1ns/1ns
`include "occ_regs.svh"

module testbench;
    logic        clock, reset, read, write, waitrequest, irq, stepButton, goButton;
    logic        lockoutProgram, stopOnError, funcDriveValid, memWrite, memRead;
    logic        runEnable, errorLamp, buzzer, haltLamp, corrupt;
    logic [5:0]  address, resetButtons;
    logic [31:0] writedata, readdata, rd, r;
    logic [3:0]  byteenable, funcDriveOperand;
    logic [2:0]  modeSel;
    logic [12:0] memAddr, pcOut, errLocOut, base;
    logic [17:0] toggleUp, toggleDown, memWrData, memRdData, regAOut, regBOut, regCOut;
    logic [17:0] readoutOut, stageOut, w0, w1;
    logic [5:0]  offs [4] = '{6'h08, 6'h04, 6'h00, 6'h1c};
    int          lm [4] = '{1, 2, 4, 0};
    integer      seed;
    int          badCount;
    int          checksDone;

    operator_console_control operator_console_control_inst (
        .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .toggleUp(toggleUp), .toggleDown(toggleDown),
        .modeSel(modeSel), .stepButton(stepButton), .goButton(goButton),
        .lockoutProgram(lockoutProgram), .stopOnError(stopOnError),
        .resetButtons(resetButtons), .funcDriveValid(funcDriveValid),
        .funcDriveOperand(funcDriveOperand), .memAddr(memAddr), .memWrData(memWrData),
        .memWrite(memWrite), .memRead(memRead), .memRdData(memRdData),
        .runEnable(runEnable), .pcOut(pcOut), .regAOut(regAOut), .regBOut(regBOut),
        .regCOut(regCOut), .readoutOut(readoutOut), .stageOut(stageOut),
        .errLocOut(errLocOut), .errorLamp(errorLamp), .buzzer(buzzer), .haltLamp(haltLamp)
    );

    occ_memory_model occ_memory_model_inst (
        .clock(clock), .memAddr(memAddr), .memWrData(memWrData), .memWrite(memWrite),
        .memRead(memRead), .corrupt(corrupt), .memRdData(memRdData)
    );

    // free-running processor clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // compare and count
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        if (badCount == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge clock);
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            badCount++;
            summarize();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // let the edge that took the request settle before anyone looks
        wt(1);
    endtask

    // operator sets a word; each one bit lands randomly up or down, zeros centred
    task automatic tog(input logic [17:0] v);
        r = $random(seed);
        toggleUp <= v & r[17:0];
        toggleDown <= v & ~r[17:0];
    endtask

    // operator presses and releases step or go
    task automatic press(input bit go);
        if (go) begin
            goButton <= 1'b1;
        end else begin
            stepButton <= 1'b1;
        end
        wt(5);
        goButton <= 1'b0;
        stepButton <= 1'b0;
        wt(6);
    endtask

    // function drive instruction pulse
    task automatic fd(input logic [3:0] op);
        funcDriveValid <= 1'b1;
        funcDriveOperand <= op;
        wt(1);
        funcDriveValid <= 1'b0;
        wt(3);
    endtask

    task automatic mode(input logic [2:0] m);
        modeSel <= m;
        wt(5);
    endtask

    // register outputs in reset button order
    function automatic logic [17:0] pick(input int i);
        case (i)
            0: pick = {5'h0, pcOut};
            1: pick = regAOut;
            2: pick = regBOut;
            3: pick = readoutOut;
            4: pick = regCOut;
            default: pick = stageOut;
        endcase
    endfunction

    // hang guard
    initial begin
        wt(20000);
        badCount++;
        summarize();
    end

    // main sequence
    initial begin
        seed = 32'h9ff7;
        badCount = 0;
        checksDone = 0;
        {reset, read, write, stepButton, goButton, lockoutProgram} = 6'h20;
        {stopOnError, funcDriveValid, corrupt} = 3'h0;
        {address, writedata, byteenable, funcDriveOperand} = {38'h0, 4'hf, 4'h0};
        {toggleUp, toggleDown, modeSel, resetButtons} = '0;
        wt(12);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, offs[i], 32'h0);
            cmp(rd, (i == 0), "reset value or unmapped read");
        end
        for (int m = 0; m < 4; m++) begin
            w0 = $random(seed);
            tog(w0);
            mode(3'(m));
            cmp(pick(lm[m]), (m == 3) ? (w0 & 18'h1fff) : w0, "panel load");
        end
        base = w0[12:0];
        w0 = $random(seed);
        w1 = ~w0;
        // leave set p before new toggles arrive, or pc would follow them
        mode(`OCC_CODE_DEPOSIT);
        tog(w0);
        wt(5);
        cmp(stageOut, w0, "staging mirror");
        bus(1'b1, `OCC_MASK_OFS, 32'hf);
        press(1'b0);
        cmp(occ_memory_model_inst.store[base], w0, "deposit data");
        cmp(pcOut, 13'(base + 13'h1), "deposit pc");
        cmp({irq, haltLamp, errorLamp}, 3'b100, "clean deposit");
        bus(1'b1, `OCC_STATUS_OFS, 32'hf);
        cmp(irq, 1'b0, "status clear");
        corrupt <= 1'b1;
        tog(w1);
        press(1'b0);
        corrupt <= 1'b0;
        cmp({haltLamp, errorLamp, buzzer}, 3'b111, "readback mismatch");
        bus(1'b0, `OCC_STATUS_OFS, 32'h0);
        cmp(rd[`OCC_EV_MISMATCH], 1'b1, "mismatch event");
        fd(`OCC_FD_LAMP_OFF);
        cmp({errorLamp, buzzer}, 2'b00, "lamp off");
        tog({5'h0, base});
        mode(`OCC_CODE_SET_P);
        mode(`OCC_CODE_EXEC);
        press(1'b0);
        tog(w0);
        mode(`OCC_CODE_EXAMINE);
        press(1'b0);
        cmp({readoutOut, pcOut}, {w0, base + 13'h1}, "examine");
        cmp(haltLamp, 1'b0, "examine match");
        press(1'b0);
        cmp({readoutOut, haltLamp, errorLamp}, {w1, 2'b11}, "examine mismatch");
        fd(`OCC_FD_LAMP_OFF);
        mode(`OCC_CODE_EXEC);
        press(1'b1);
        cmp({runEnable, pcOut}, {1'b1, base + 13'h2}, "go starts at pc");
        fd(`OCC_FD_LAMP_ON);
        cmp({runEnable, errorLamp, haltLamp}, 3'b100, "lamp while running");
        bus(1'b0, `OCC_STATE_OFS, 32'h0);
        cmp(rd[`OCC_ST_LAMP], 1'b1, "lamp on by instruction");
        fd(`OCC_FD_LAMP_OFF);
        mode(`OCC_CODE_DEPOSIT);
        cmp(runEnable, 1'b0, "no run outside execute");
        stopOnError <= 1'b1;
        press(1'b1);
        fd(`OCC_FD_LAMP_ON);
        cmp({haltLamp, errorLamp, errLocOut}, {2'b11, base + 13'h2}, "stop on error");
        stopOnError <= 1'b0;
        fd(`OCC_FD_LAMP_OFF);
        bus(1'b1, `OCC_MASK_OFS, 32'h0);
        cmp(irq, 1'b0, "masked");
        bus(1'b1, `OCC_MASK_OFS, 32'hf);
        cmp(irq, 1'b1, "unmasked");
        lockoutProgram <= 1'b1;
        wt(5);
        cmp(runEnable, 1'b1, "lockout forces run");
        press(1'b0);
        resetButtons <= 6'h3f;
        wt(5);
        cmp(pcOut, 13'(base + 13'h2), "lockout ignores step and reset");
        bus(1'b0, `OCC_PC_OFS, 32'h0);
        cmp(rd, {19'h0, 13'(base + 13'h2)}, "pc over bus");
        resetButtons <= 6'h0;
        lockoutProgram <= 1'b0;
        wt(5);
        mode(`OCC_CODE_EXAMINE);
        for (int i = 0; i < 6; i++) begin
            resetButtons <= 6'(1 << i);
            wt(4);
            cmp(pick(i), 18'h0, "reset button");
            resetButtons <= 6'h0;
            wt(3);
        end
        summarize();
    end
endmodule
